// >>> logic/cmx_pkg.sv
// Package for the compatibility-mode exception and trace unit.
// Assumes a single processor clock; all constants shared by the unit live here.
package cmx_pkg;
    localparam int unsigned CODE_W = 16;
    localparam logic [15:0] CODE_RSVD_INSN = 16'h0000;
    localparam logic [15:0] CODE_BREAKPOINT = 16'h0001;
    localparam logic [15:0] CODE_IO_TRAP = 16'h0002;
    localparam logic [15:0] CODE_EMULATOR = 16'h0003;
    localparam logic [15:0] CODE_TRAP_GRP = 16'h0004;
    localparam logic [15:0] CODE_ILLEGAL = 16'h0005;
    localparam logic [15:0] CODE_ODD_ADDR = 16'h0006;
    // Status longword field positions
    localparam int unsigned PSL_TBIT_POS = 4;
    localparam int unsigned PSL_IPL_LO = 16;
    localparam int unsigned PSL_IPL_HI = 20;
    localparam int unsigned PSL_IS_POS = 26;
    localparam int unsigned PSL_TP_POS = 30;
    localparam int unsigned PSL_CM_POS = 31;
    localparam logic [31:0] PSL_RST = 32'h0000_0000;
    localparam logic [1:0] FRAME_LW_EXC = 2'h3;
    localparam logic [1:0] FRAME_LW_TRACE = 2'h2;

    // Delivery class; no compatibility event is ever a trap
    typedef enum logic [1:0] {
        CMX_KIND_NONE = 2'b00,
        CMX_KIND_FAULT = 2'b01,
        CMX_KIND_ABORT = 2'b10,
        CMX_KIND_TRACE = 2'b11
    } cmx_kind_t;

    typedef enum logic [1:0] {
        CMX_ST_IDLE = 2'b00,
        CMX_ST_PUSH = 2'b01,
        CMX_ST_DONE = 2'b10
    } cmx_state_t;
endpackage : cmx_pkg

// >>> logic/cmx_frame_if.sv
// Carrier between the exception sequencer and the frame pusher.
// Assumes both ends on the same processor clock.
`timescale 1ns/1ps
interface cmx_frame_if;
    logic start;
    logic [1:0] count;
    logic [31:0] lw0;
    logic [31:0] lw1;
    logic [31:0] lw2;
    logic busy;
    logic done;
    modport seq (output start, output count, output lw0, output lw1, output lw2,
        input busy, input done);
    modport push (input start, input count, input lw0, input lw1, input lw2,
        output busy, output done);
endinterface : cmx_frame_if

// >>> logic/cmx_frame_push.sv
// Pushes a two- or three-longword frame onto the kernel stack, one word a cycle.
// Assumes the stack write port accepts a word every cycle.
`timescale 1ns/1ps
module cmx_frame_push (
    input wire logic CLK,
    input wire logic ARST_N,
    cmx_frame_if.push fr,
    output logic stk_we,
    output logic [31:0] stk_data
);
    logic [1:0] left_r;
    logic [1:0] left_nxt;
    logic [31:0] word_sel;
    logic [31:0] w0_r;
    logic [31:0] w1_r;
    logic [31:0] w2_r;

    // Extra information word goes first so status and PC end on top
    assign word_sel = (left_r == 2'h3) ? w2_r : ((left_r == 2'h2) ? w1_r : w0_r);
    assign left_nxt = fr.start ? fr.count : ((left_r != 2'h0) ? left_r - 2'h1 : 2'h0);
    assign fr.busy = (left_r != 2'h0);
    assign fr.done = (left_r == 2'h1);
    assign stk_we = (left_r != 2'h0);
    assign stk_data = word_sel;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            left_r <= 2'h0;
            w0_r <= 32'h0000_0000;
            w1_r <= 32'h0000_0000;
            w2_r <= 32'h0000_0000;
        end else begin
            left_r <= left_nxt;
            if (fr.start) begin
                w0_r <= fr.lw0;
                w1_r <= fr.lw1;
                w2_r <= fr.lw2;
            end
        end
    end
endmodule : cmx_frame_push

// >>> logic/cmx_trace_ctl.sv
// Trace-pending bookkeeping at instruction boundaries.
// Assumes insn_start and insn_end are one-cycle pulses from the sequencer.
`timescale 1ns/1ps
module cmx_trace_ctl (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic insn_start,
    input wire logic insn_end,
    input wire logic tbit,
    input wire logic is_return,
    input wire logic popped_tbit,
    input wire logic fault_now,
    input wire logic trace_taken,
    input wire logic tp_load,
    input wire logic tp_load_val,
    output logic tp,
    output logic trace_due,
    output logic tbit_saved
);
    logic tp_r;
    logic tp_nxt;
    logic ret_r;
    logic ret_t_r;

    // A fault clears trace-pending, even when its instruction armed it at start
    assign tp_nxt = tp_load ? tp_load_val :
                    trace_taken ? 1'b0 :
                    (insn_start && tbit && !tp_r) ? 1'b1 : tp_r;
    assign tp = tp_r;
    assign trace_due = tp_r && insn_start;
    // Return instructions save the popped image's T, others save the current status T
    assign tbit_saved = ret_r ? ret_t_r : tbit;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tp_r <= 1'b0;
            ret_r <= 1'b0;
            ret_t_r <= 1'b0;
        end else begin
            tp_r <= fault_now ? 1'b0 : tp_nxt;
            if (insn_end) begin
                ret_r <= is_return;
                ret_t_r <= popped_tbit;
            end else if (trace_taken) begin
                ret_r <= 1'b0;
            end
        end
    end
endmodule : cmx_trace_ctl

// >>> logic/cmx_exc_unit.sv
// Compatibility-mode exception and trace unit: classifies events, pushes frames.
// Assumes an instruction decoder reports each event as a one-cycle pulse in insn cycle.
//
// Contract
// - Any compat event returns to native mode
// - Compat exceptions push three-longword kernel frame
// - Info longword: code low, upper zero
// - Compat exceptions are faults or aborts only
// - Odd-address word reference aborts, code 6
// - Reserved opcode faults with code 0
// - Breakpoint, IO, emulator, trap faults 1-4
// - Register-destination jump/call faults with code 5
// - Trace fault when T set previous instruction
// - Trace frame two longwords, INTERRUPT_PRIORITY_LEVEL/IS zero, compat one
// - Trace uses native trace vector and rules
// - Fetch odd-address abort may precede trace
// - T set, TP clear: set TP, then trace
// - Returns save popped T, TP clear
// - Faulting instruction serviced first, TP clear
// - Native return into traced compat: one instruction
// - No stack-overflow or double-error traps here
// - Only condition codes reachable in compat mode
// - Modify destinations interlock IO registers only
// - Self-written code executes without extra sync
`timescale 1ns/1ps
module cmx_exc_unit (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic INSN_START,
    input wire logic INSN_END,
    input wire logic [31:0] STATUS_IN,
    input wire logic [31:0] PC_IN,
    input wire logic ODD_WORD_REF,
    input wire logic ODD_IS_FETCH,
    input wire logic RSVD_OPCODE,
    input wire logic BREAKPOINT_INSTRUCTION,
    input wire logic IO_TRAP_INSTRUCTION,
    input wire logic EMULATOR_TRAP_INSTRUCTION,
    input wire logic TRAP_GROUP_INSTRUCTION,
    input wire logic JUMP_REG_DEST,
    input wire logic OTHER_EXCEPTION,
    input wire logic IS_RETURN,
    input wire logic POPPED_TBIT,
    input wire logic NATIVE_RETURN,
    input wire logic [31:0] RETURN_STATUS,
    input wire logic PREG_ACCESS,
    input wire logic PREG_IS_CC,
    input wire logic MODIFY_DEST,
    input wire logic DEST_IS_IO,
    input wire logic MEM_WRITE,
    output logic COMPAT_MODE,
    output logic TRACE_PENDING,
    output logic EXC_ACTIVE,
    output logic [1:0] EXC_KIND,
    output logic [15:0] EXC_CODE,
    output logic TRACE_VECTOR_SEL,
    output logic BACKOUT,
    output logic STACK_WE,
    output logic [31:0] STACK_DATA,
    output logic FRAME_DONE,
    output logic BUS_INTERLOCK,
    output logic PREG_REFUSED,
    output logic FETCH_FLUSH
);
    cmx_frame_if fr ();

    cmx_pkg::cmx_state_t state_r;
    cmx_pkg::cmx_state_t state_nxt;
    logic compat_r;
    logic [1:0] kind_r;
    logic [15:0] code_r;
    logic trvec_r;
    logic [31:0] psl_r;
    logic [31:0] pc_r;
    logic [1:0] cnt_r;
    logic start_r;
    logic interlock_r;
    logic flush_r;
    logic preg_r;
    logic backout_r;

    logic compat_nxt;
    logic [1:0] kind_nxt;
    logic [15:0] code_nxt;
    logic trvec_nxt;
    logic [31:0] psl_nxt;
    logic [31:0] pc_nxt;
    logic [1:0] cnt_nxt;
    logic start_nxt;
    logic backout_nxt;
    logic interlock_nxt;
    logic flush_nxt;
    logic preg_nxt;

    logic tp;
    logic trace_due;
    logic tbit_saved;
    logic tbit;
    logic odd_hit;
    logic fault_hit;
    logic exc_hit;
    logic trace_hit;
    logic odd_first;
    logic take;
    logic [15:0] fault_code;
    logic [31:0] trace_psl;
    logic [31:0] exc_psl;
    logic enter_compat;
    logic idle;

    logic take_exc;
    logic take_trace;
    logic take_plain;
    logic in_done;
    logic compat_load;
    logic [15:0] exc_code;
    logic tr_start;
    logic tr_end;
    logic tr_fault;
    logic tr_taken;
    logic [10:0] trace_top;
    logic [20:0] trace_low;

    assign idle = (state_r == cmx_pkg::CMX_ST_IDLE);
    assign tbit = STATUS_IN[cmx_pkg::PSL_TBIT_POS];
    assign odd_hit = compat_r && ODD_WORD_REF;
    assign fault_hit = compat_r && (RSVD_OPCODE || BREAKPOINT_INSTRUCTION ||
        IO_TRAP_INSTRUCTION || EMULATOR_TRAP_INSTRUCTION || TRAP_GROUP_INSTRUCTION ||
        JUMP_REG_DEST);
    assign exc_hit = odd_hit || fault_hit;
    assign trace_hit = compat_r && trace_due;
    // Fetch odd-address abort is allowed to beat the pending trace
    assign odd_first = odd_hit && ODD_IS_FETCH;
    assign take = idle && !fr.busy && (exc_hit || trace_hit || (compat_r && OTHER_EXCEPTION));

    // Priority among simultaneous decode events
    assign fault_code = RSVD_OPCODE ? cmx_pkg::CODE_RSVD_INSN :
        BREAKPOINT_INSTRUCTION ? cmx_pkg::CODE_BREAKPOINT :
        IO_TRAP_INSTRUCTION ? cmx_pkg::CODE_IO_TRAP :
        EMULATOR_TRAP_INSTRUCTION ? cmx_pkg::CODE_EMULATOR :
        TRAP_GROUP_INSTRUCTION ? cmx_pkg::CODE_TRAP_GRP :
        cmx_pkg::CODE_ILLEGAL;

    // Stacked status: compat set, TP clear; the trace image also forces INTERRUPT_PRIORITY_LEVEL and IS low
    assign trace_top = {1'b1, 1'b0, STATUS_IN[29:27], 1'b0, STATUS_IN[25:21]};
    assign trace_low = {5'h00, STATUS_IN[15:5], tbit_saved, STATUS_IN[3:0]};
    assign trace_psl = {trace_top, trace_low};
    assign exc_psl = {1'b1, 1'b0, STATUS_IN[29:5], tbit, STATUS_IN[3:0]};

    // TP comes from the popped image: with T set and TP clear exactly one
    // instruction runs before the trace
    assign enter_compat = NATIVE_RETURN && RETURN_STATUS[cmx_pkg::PSL_CM_POS];
    assign compat_load = idle && enter_compat;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            cmx_pkg::CMX_ST_IDLE: begin
                if (take_plain) begin
                    // No compat frame to wait for, so skip the push
                    state_nxt = cmx_pkg::CMX_ST_DONE;
                end else if (take) begin
                    state_nxt = cmx_pkg::CMX_ST_PUSH;
                end
            end
            cmx_pkg::CMX_ST_PUSH: begin
                if (fr.done) begin
                    state_nxt = cmx_pkg::CMX_ST_DONE;
                end
            end
            cmx_pkg::CMX_ST_DONE: state_nxt = cmx_pkg::CMX_ST_IDLE;
            default: state_nxt = cmx_pkg::CMX_ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= cmx_pkg::CMX_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Faults beat a pending trace; an odd-address abort only when fetched
    assign take_exc = take && exc_hit && (odd_first || !trace_hit || fault_hit);
    assign take_trace = take && trace_hit && !take_exc;
    assign take_plain = take && !exc_hit && !trace_hit;
    assign in_done = (state_r == cmx_pkg::CMX_ST_DONE);
    assign exc_code = odd_hit ? cmx_pkg::CODE_ODD_ADDR : fault_code;

    assign tr_start = INSN_START && compat_r && idle;
    assign tr_end = INSN_END && compat_r;
    assign tr_fault = take && exc_hit;
    assign tr_taken = take && trace_hit && !(exc_hit && odd_first);

    // Every event drops compat, whether or not it pushes a frame
    assign compat_nxt = take ? 1'b0 : (compat_load ? 1'b1 : compat_r);
    assign start_nxt = take && (exc_hit || trace_hit);
    assign backout_nxt = take ? (exc_hit || OTHER_EXCEPTION) :
        ((compat_load || in_done) ? 1'b0 : backout_r);
    assign pc_nxt = take ? {16'h0000, PC_IN[15:0]} : pc_r;
    // Faults, aborts and traces only, never a trap
    assign kind_nxt = take_exc ?
        (odd_hit ? cmx_pkg::CMX_KIND_ABORT : cmx_pkg::CMX_KIND_FAULT) :
        (take_trace ? cmx_pkg::CMX_KIND_TRACE :
        ((take_plain || in_done) ? cmx_pkg::CMX_KIND_NONE : kind_r));
    assign code_nxt = take_exc ? exc_code : (take ? 16'h0000 : code_r);
    assign trvec_nxt = take_trace ? 1'b1 : ((take || in_done) ? 1'b0 : trvec_r);
    assign psl_nxt = take_exc ? exc_psl : (take_trace ? trace_psl : psl_r);
    assign cnt_nxt = take_exc ? cmx_pkg::FRAME_LW_EXC :
        (take_trace ? cmx_pkg::FRAME_LW_TRACE : cnt_r);

    // Interlock only IO registers, never memory; condition codes only
    assign interlock_nxt = compat_r && MODIFY_DEST && DEST_IS_IO;
    assign flush_nxt = compat_r && MEM_WRITE;
    assign preg_nxt = compat_r && PREG_ACCESS && !PREG_IS_CC;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            compat_r <= 1'b0;
            kind_r <= cmx_pkg::CMX_KIND_NONE;
            code_r <= 16'h0000;
            trvec_r <= 1'b0;
            backout_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            compat_r <= compat_nxt;
            kind_r <= kind_nxt;
            code_r <= code_nxt;
            trvec_r <= trvec_nxt;
            backout_r <= backout_nxt;
            start_r <= start_nxt;
        end
    end

    // Frame words held until the pusher latches them
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            psl_r <= cmx_pkg::PSL_RST;
            pc_r <= 32'h0000_0000;
            cnt_r <= 2'h0;
        end else begin
            psl_r <= psl_nxt;
            pc_r <= pc_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            interlock_r <= 1'b0;
            flush_r <= 1'b0;
            preg_r <= 1'b0;
        end else begin
            interlock_r <= interlock_nxt;
            flush_r <= flush_nxt;
            preg_r <= preg_nxt;
        end
    end

    assign fr.start = start_r;
    assign fr.count = cnt_r;
    assign fr.lw0 = psl_r;
    assign fr.lw1 = pc_r;
    assign fr.lw2 = {16'h0000, code_r};

    cmx_frame_push u_push (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .fr(fr),
        .stk_we(STACK_WE),
        .stk_data(STACK_DATA)
    );

    cmx_trace_ctl u_trace (
        .CLK(CLK),
        .ARST_N(ARST_N),
        .insn_start(tr_start),
        .insn_end(tr_end),
        .tbit(tbit),
        .is_return(IS_RETURN),
        .popped_tbit(POPPED_TBIT),
        .fault_now(tr_fault),
        .trace_taken(tr_taken),
        .tp_load(compat_load),
        .tp_load_val(RETURN_STATUS[cmx_pkg::PSL_TP_POS]),
        .tp(tp),
        .trace_due(trace_due),
        .tbit_saved(tbit_saved)
    );

    assign COMPAT_MODE = compat_r;
    assign TRACE_PENDING = tp;
    assign EXC_ACTIVE = !idle;
    assign EXC_KIND = kind_r;
    assign EXC_CODE = code_r;
    assign TRACE_VECTOR_SEL = trvec_r;
    assign BACKOUT = backout_r;
    assign FRAME_DONE = fr.done;
    assign BUS_INTERLOCK = interlock_r;
    assign PREG_REFUSED = preg_r;
    assign FETCH_FLUSH = flush_r;
endmodule : cmx_exc_unit

// >>> sim/cmx_exc_unit_properties.sv
// Port-level checks for the compatibility exception unit.
// Assumes the one processor clock and the asynchronous low reset.
`timescale 1ns/1ps
module cmx_exc_chk (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic INSN_START,
    input wire logic ODD_WORD_REF,
    input wire logic RSVD_OPCODE,
    input wire logic JUMP_REG_DEST,
    input wire logic OTHER_EXCEPTION,
    input wire logic PREG_ACCESS,
    input wire logic PREG_IS_CC,
    input wire logic MODIFY_DEST,
    input wire logic DEST_IS_IO,
    input wire logic COMPAT_MODE,
    input wire logic TRACE_PENDING,
    input wire logic EXC_ACTIVE,
    input wire logic [1:0] EXC_KIND,
    input wire logic [15:0] EXC_CODE,
    input wire logic TRACE_VECTOR_SEL,
    input wire logic STACK_WE,
    input wire logic [31:0] STACK_DATA,
    input wire logic FRAME_DONE,
    input wire logic BUS_INTERLOCK,
    input wire logic PREG_REFUSED
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    wire logic ok = COMPAT_MODE && !EXC_ACTIVE;
    property p_rsvd;
        ok && RSVD_OPCODE |=> EXC_KIND == 2'h1 && EXC_CODE == 16'h0000 && !COMPAT_MODE;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved opcode fault wrong");
    property p_jump;
        ok && JUMP_REG_DEST && !RSVD_OPCODE |=> EXC_KIND == 2'h1 && EXC_CODE == 16'h0005;
    endproperty
    a_jump: assert property (p_jump) else $error("illegal jump fault wrong");
    property p_odd;
        ok && ODD_WORD_REF |=> EXC_KIND == 2'h2 && EXC_CODE == 16'h0006;
    endproperty
    a_odd: assert property (p_odd) else $error("odd address abort wrong");
    property p_leave;
        ok && OTHER_EXCEPTION |=> !COMPAT_MODE;
    endproperty
    a_leave: assert property (p_leave) else $error("other exception kept compat");
    // Other exceptions leave for native dispatch without a compat frame
    property p_frame3;
        $rose(EXC_ACTIVE) && EXC_KIND != 2'h3 && !$past(OTHER_EXCEPTION) |->
            ##1 STACK_WE [*3] ##1 !STACK_WE;
    endproperty
    a_frame3: assert property (p_frame3) else $error("exception frame length");
    property p_info;
        $rose(EXC_ACTIVE) && EXC_KIND != 2'h3 && !$past(OTHER_EXCEPTION) |->
            ##1 STACK_DATA == {16'h0000, EXC_CODE};
    endproperty
    a_info: assert property (p_info) else $error("info longword wrong");
    property p_frame2;
        $rose(EXC_ACTIVE) && EXC_KIND == 2'h3 |->
            TRACE_VECTOR_SEL ##1 STACK_WE [*2] ##1 !STACK_WE;
    endproperty
    a_frame2: assert property (p_frame2) else $error("trace frame wrong");
    property p_tpsl;
        $rose(EXC_ACTIVE) && EXC_KIND == 2'h3 |->
            ##2 (STACK_DATA & 32'h441F_0000) == 32'h0 && STACK_DATA[31];
    endproperty
    a_tpsl: assert property (p_tpsl) else $error("trace status wrong");
    property p_done;
        $rose(EXC_ACTIVE) && (EXC_KIND == 2'h3 || !$past(OTHER_EXCEPTION)) |->
            ##[2:3] FRAME_DONE;
    endproperty
    a_done: assert property (p_done) else $error("frame never done");
    property p_trace;
        ok && INSN_START && TRACE_PENDING && !ODD_WORD_REF |=> EXC_KIND == 2'h3;
    endproperty
    a_trace: assert property (p_trace) else $error("pending trace not taken");
    property p_lock;
        COMPAT_MODE && MODIFY_DEST && !DEST_IS_IO |=> !BUS_INTERLOCK;
    endproperty
    a_lock: assert property (p_lock) else $error("memory interlocked");
    property p_preg;
        COMPAT_MODE && PREG_ACCESS && !PREG_IS_CC |=> PREG_REFUSED;
    endproperty
    a_preg: assert property (p_preg) else $error("register access allowed");
endmodule : cmx_exc_chk
bind cmx_exc_unit cmx_exc_chk chk_u (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .INSN_START(INSN_START),
    .ODD_WORD_REF(ODD_WORD_REF),
    .RSVD_OPCODE(RSVD_OPCODE),
    .JUMP_REG_DEST(JUMP_REG_DEST),
    .OTHER_EXCEPTION(OTHER_EXCEPTION),
    .PREG_ACCESS(PREG_ACCESS),
    .PREG_IS_CC(PREG_IS_CC),
    .MODIFY_DEST(MODIFY_DEST),
    .DEST_IS_IO(DEST_IS_IO),
    .COMPAT_MODE(COMPAT_MODE),
    .TRACE_PENDING(TRACE_PENDING),
    .EXC_ACTIVE(EXC_ACTIVE),
    .EXC_KIND(EXC_KIND),
    .EXC_CODE(EXC_CODE),
    .TRACE_VECTOR_SEL(TRACE_VECTOR_SEL),
    .STACK_WE(STACK_WE),
    .STACK_DATA(STACK_DATA),
    .FRAME_DONE(FRAME_DONE),
    .BUS_INTERLOCK(BUS_INTERLOCK),
    .PREG_REFUSED(PREG_REFUSED)
);

// >>> sim/tb_compat_mode_exception_trace.sv
// Self-checking bench for the compatibility exception unit.
// Assumes the unit under test drives outputs from CLK; inputs move 1 ns after it.
`timescale 1ns/1ps
module tb_compat_mode_exception_trace;
    logic CLK = 1'b0, ARST_N = 1'b0, ist = 1'b0, iend = 1'b0, isret = 1'b0, pop = 1'b0;
    logic nret = 1'b0, pacc = 1'b0, pcc = 1'b0, mdst = 1'b0, dio = 1'b0, mwr = 1'b0;
    logic [8:0] ev = 9'h000;
    logic [31:0] st = 32'h0, pc = 32'h0000_1234, rst_st = 32'h0;
    logic [31:0] w [0:3];
    logic cm, tp, act, tvs, bo, we, fd, lk, prf, ff;
    logic [1:0] kd;
    logic [15:0] cd;
    logic [31:0] sd;
    int fail_count = 0, checks = 0, n;
    cmx_exc_unit dut_u (.CLK(CLK), .ARST_N(ARST_N), .INSN_START(ist), .INSN_END(iend),
        .STATUS_IN(st), .PC_IN(pc), .ODD_WORD_REF(ev[6] | ev[7]), .ODD_IS_FETCH(ev[7]),
        .RSVD_OPCODE(ev[0]), .BREAKPOINT_INSTRUCTION(ev[1]), .IO_TRAP_INSTRUCTION(ev[2]),
        .EMULATOR_TRAP_INSTRUCTION(ev[3]), .TRAP_GROUP_INSTRUCTION(ev[4]),
        .JUMP_REG_DEST(ev[5]), .OTHER_EXCEPTION(ev[8]), .IS_RETURN(isret),
        .POPPED_TBIT(pop), .NATIVE_RETURN(nret), .RETURN_STATUS(rst_st), .PREG_ACCESS(pacc),
        .PREG_IS_CC(pcc), .MODIFY_DEST(mdst), .DEST_IS_IO(dio), .MEM_WRITE(mwr),
        .COMPAT_MODE(cm), .TRACE_PENDING(tp), .EXC_ACTIVE(act), .EXC_KIND(kd),
        .EXC_CODE(cd), .TRACE_VECTOR_SEL(tvs), .BACKOUT(bo), .STACK_WE(we),
        .STACK_DATA(sd), .FRAME_DONE(fd), .BUS_INTERLOCK(lk), .PREG_REFUSED(prf),
        .FETCH_FLUSH(ff));
    initial begin
        forever #4 CLK = ~CLK;
    end
    task automatic tick;
        @(posedge CLK);
        #1;
    endtask : tick
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic conclude;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic enter(input logic [31:0] s);
        nret = 1'b1;
        rst_st = s;
        tick();
        nret = 1'b0;
        cmp(cm, 1'b1);
    endtask : enter
    // Collects the pushed words; a bounded wait guards against a hung pusher
    task automatic frame;
        n = 0;
        for (int i = 0; i < 8 && we !== 1'b1; i++) tick();
        while (we === 1'b1 && n < 4) begin
            w[n] = sd;
            n++;
            tick();
        end
        for (int i = 0; i < 8 && act !== 1'b0; i++) tick();
        cmp(act, 1'b0);
    endtask : frame
    task automatic t_codes;
        for (int i = 0; i < 8; i++) begin
            enter(32'h8000_0000);
            st = 32'h8000_0000;
            ev = 9'h001 << i;
            tick();
            ev = 9'h000;
            cmp(kd, (i < 6) ? 2'h1 : 2'h2);
            cmp(cd, (i < 6) ? i : 6);
            cmp(cm, 1'b0);
            cmp(bo, 1'b1);
            frame();
            cmp(n, 3);
            cmp(w[0], (i < 6) ? i : 6);
            cmp(w[1], pc);
            cmp(w[2], 32'h8000_0000);
        end
        enter(32'h8000_0000);
        ev = 9'h100;
        tick();
        ev = 9'h000;
        cmp(cm, 1'b0);
        cmp(bo, 1'b1);
        cmp(kd, 2'h0);
        frame();
        cmp(n, 0);
        $display("test codes done");
    endtask : t_codes
    task automatic t_refuse;
        ev = 9'h001;
        tick();
        ev = 9'h000;
        tick();
        cmp(act, 1'b0);
        $display("test refuse done");
    endtask : t_refuse
    // Entry from native return with T set, then one instruction before the trace
    task automatic t_trace(input logic ret, input logic pb);
        enter(32'h8000_0010);
        st = 32'h8415_0010;
        ist = 1'b1;
        tick();
        ist = 1'b0;
        iend = 1'b1;
        isret = ret;
        pop = pb;
        tick();
        {iend, isret, pop} = 3'b000;
        tick();
        cmp(tp, 1'b1);
        ist = 1'b1;
        tick();
        ist = 1'b0;
        cmp(kd, 2'h3);
        cmp(tvs, 1'b1);
        frame();
        cmp(n, 2);
        cmp(w[0], pc);
        cmp(w[1] & 32'hC41F_0010, {27'h4000000, ret ? pb : 1'b1, 4'h0});
        $display("test trace done");
    endtask : t_trace
    task automatic t_fault_first;
        enter(32'h8000_0010);
        st = 32'h8000_0010;
        ist = 1'b1;
        tick();
        ist = 1'b0;
        ev = 9'h001;
        tick();
        ev = 9'h000;
        cmp(kd, 2'h1);
        cmp(tp, 1'b0);
        frame();
        cmp(w[2] & 32'hC000_0010, 32'h8000_0010);
        $display("test fault first done");
    endtask : t_fault_first
    // Odd fetch address while a trace is due: the abort goes first
    task automatic t_odd_fetch;
        enter(32'h8000_0010);
        st = 32'h8000_0010;
        ist = 1'b1;
        tick();
        ist = 1'b0;
        tick();
        cmp(tp, 1'b1);
        ist = 1'b1;
        ev = 9'h080;
        tick();
        {ist, ev} = 10'h000;
        cmp(kd, 2'h2);
        cmp(cd, 16'h0006);
        frame();
        cmp(n, 3);
        $display("test odd fetch done");
    endtask : t_odd_fetch
    // Stimulus aims one compat modify destination at IO space, then one at memory
    task automatic t_misc;
        enter(32'h8000_0000);
        {pacc, pcc} = 2'b10;
        tick();
        cmp(prf, 1'b1);
        pcc = 1'b1;
        tick();
        cmp(prf, 1'b0);
        {pacc, mdst, dio} = 3'b011;
        tick();
        cmp(lk, 1'b1);
        dio = 1'b0;
        tick();
        cmp(lk, 1'b0);
        {mdst, mwr} = 2'b01;
        tick();
        mwr = 1'b0;
        cmp(ff, 1'b1);
        $display("test misc done");
    endtask : t_misc
    initial begin
        #20000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge CLK);
        #1;
        ARST_N = 1'b1;
        cmp(cm, 1'b0);
        t_refuse();
        t_codes();
        t_trace(1'b0, 1'b0);
        t_trace(1'b1, 1'b0);
        t_trace(1'b1, 1'b1);
        t_fault_first();
        t_odd_fetch();
        t_misc();
        conclude();
    end
endmodule : tb_compat_mode_exception_trace
